/* ustw_master.sv */
`timescale 1ns/10ps
`default_nettype none
module ustw_master
(
    // wire level seen on the bus
    input  wire logic scl_line,
    // open-drain drives, 1 = released
    output logic      scl_drv,
    output logic      sda_drv,
    // status
    output logic      stretch_timeout
);
    initial
    begin
        scl_drv         = 1'b1;
        sda_drv         = 1'b1;
        stretch_timeout = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // half a link period per step
    task automatic edge_scl(input logic level);
        scl_drv = level;
        #62.5;
    endtask

    task automatic start_cond;
        sda_drv = 1'b0;
        #62.5;
        edge_scl(1'b0);
    endtask

    task automatic stop_cond;
        sda_drv = 1'b0;
        #62.5;
        edge_scl(1'b1);
        sda_drv = 1'b1;
        #62.5;
    endtask

    task automatic send_bit(input logic b);
        int n;
        sda_drv = b;
        #62.5;
        scl_drv = 1'b1;
        #62.5;
        n = 0;
        while (scl_line !== 1'b1 && n < 40)
        begin
            #62.5;
            n++;
        end
        if (n == 40)
            stretch_timeout = 1'b1;
        edge_scl(1'b0);
    endtask

    task automatic send_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            send_bit(d[i]);
    endtask
endmodule
`default_nettype wire

/* ustw_pkg.sv */
package ustw_pkg;
    // wire modes
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_THREE = 2'h1;
    localparam logic [1:0] MODE_TWO   = 2'h2;
    localparam logic [1:0] MODE_TWOH  = 2'h3;
    // clock source selections
    localparam logic [1:0] CS_SOFT    = 2'h0;
    localparam logic [1:0] CS_TIMER   = 2'h1;
    localparam logic [1:0] CS_EXT_POS = 2'h2;
    localparam logic [1:0] CS_EXT_NEG = 2'h3;
    // counter
    localparam logic [3:0] CNT_MAX    = 4'hF;
    localparam logic [3:0] CNT_RESET  = 4'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // sda delay in the start detector, ns
    localparam int SDA_DELAY_MIN_NS = 50;
    localparam int SDA_DELAY_MAX_NS = 300;
    localparam int CLOCK_PERIOD_NS  = 5;
    localparam int SDA_DELAY_CYCLES =
        (SDA_DELAY_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
endpackage

/* ustw_unit.sv */
// Summary of operation
// - three-wire slave shifts byte, overflow flags completion
// - no slew limiting or input filtering
// - master clocks; only slave holds clock
// - shifting automatic on one selected clock edge only
// - slave inserts wait states holding SCL low
// - each clock edge increments edge counter
// - start detector sets start condition flag
// - hold SCL low after start until cleared
// - sample SDA into shift register on rise
// - eight bits overflow counter, SCL held low in MODE_TWOH only
// - read bit one means slave drives SDA
// - bytes repeat same direction until stop/start
// - SDA delayed versus SCL in start detector
// - start caught on SDA fall, flagged on system clock
// - external clock counts both edges
// - counter preset F overflows on next edge
// - overflow set 15 to 0, write-one clears
// - start flag clears by write-one, releases hold
// - data out from bit 7 via latch
`timescale 1ns/10ps
`default_nettype none
module ustw_unit
(
    // system
    input  wire logic       clock,
    input  wire logic       reset_n,
    // link clock (SCL / shift clock pin as a clock)
    input  wire logic       scl_clock,
    // pins
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            scl_out,
    output logic            scl_oe_n,
    // configuration
    input  wire logic [1:0] wire_mode,
    input  wire logic [1:0] clock_source,
    input  wire logic       soft_clock_strobe,
    input  wire logic       timer_overflow,
    input  wire logic       data_dir_out,
    // software writes
    input  wire logic       shift_data_write,
    input  wire logic [7:0] shift_data_wdata,
    input  wire logic       counter_write,
    input  wire logic [3:0] counter_wdata,
    input  wire logic       clear_overflow,
    input  wire logic       clear_start,
    // status
    output logic [7:0]      shift_data_register,
    output logic [3:0]      counter_value,
    output logic            counter_overflow_flag,
    output logic            start_condition_flag
);

////////////////////////////////////////////////////////////////////////////////
// link domain: toggle per scl edge, start detector

    logic       rise_tog_reg;
    logic       fall_tog_reg;
    logic       sda_link_reg;
    logic       start_tog_reg;

    // rising edges sample sda
    always_ff @(posedge scl_clock or negedge reset_n)
    begin
        if (!reset_n)
            rise_tog_reg <= 1'b0;
        else
            rise_tog_reg <= ~rise_tog_reg;
    end

    always_ff @(posedge scl_clock or negedge reset_n)
    begin
        if (!reset_n)
            sda_link_reg <= 1'b0;
        else
            sda_link_reg <= sda_in;
    end

    always_ff @(negedge scl_clock or negedge reset_n)
    begin
        if (!reset_n)
            fall_tog_reg <= 1'b0;
        else
            fall_tog_reg <= ~fall_tog_reg;
    end

    // start: sda falls while scl high; caught asynchronously on sda edge
    always_ff @(negedge sda_in or negedge reset_n)
    begin
        if (!reset_n)
            start_tog_reg <= 1'b0;
        else if (scl_clock)
            start_tog_reg <= ~start_tog_reg;
    end

////////////////////////////////////////////////////////////////////////////////
// crossings into system clock: three stages, event when second and third differ

    logic [2:0] rise_sync_reg;
    logic [2:0] fall_sync_reg;
    logic [2:0] start_sync_reg;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rise_sync_reg  <= 3'h0;
            fall_sync_reg  <= 3'h0;
            start_sync_reg <= 3'h0;
            scl_sync_reg   <= 3'h0;
            sda_sync_reg   <= 3'h0;
        end
        else
        begin
            rise_sync_reg  <= {rise_sync_reg[1:0], rise_tog_reg};
            fall_sync_reg  <= {fall_sync_reg[1:0], fall_tog_reg};
            start_sync_reg <= {start_sync_reg[1:0], start_tog_reg};
            scl_sync_reg   <= {scl_sync_reg[1:0], scl_clock};
            sda_sync_reg   <= {sda_sync_reg[1:0], sda_in};
        end
    end

    logic rise_evt;
    logic fall_evt;
    logic start_evt;
    assign rise_evt  = rise_sync_reg[2] ^ rise_sync_reg[1];
    assign fall_evt  = fall_sync_reg[2] ^ fall_sync_reg[1];
    assign start_evt = start_sync_reg[2] ^ start_sync_reg[1];

    // sda delayed relative to scl
    logic [ustw_pkg::SDA_DELAY_CYCLES-1:0] sda_pipe_reg;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            sda_pipe_reg <= '1;
        else
            sda_pipe_reg <= {sda_pipe_reg[ustw_pkg::SDA_DELAY_CYCLES-2:0],
                             sda_sync_reg[2]};
    end

    // start counts only if sda was high at the far end of the delay window
    logic start_ok;
    assign start_ok = start_evt
                      && sda_pipe_reg[ustw_pkg::SDA_DELAY_CYCLES-1];

////////////////////////////////////////////////////////////////////////////////
// clock source selection

    logic two_wire;
    logic ext_src;
    logic shift_tick;
    logic count_tick;
    assign two_wire = wire_mode[1];
    assign ext_src  = clock_source[1];

    always_comb
    begin
        shift_tick = 1'b0;
        count_tick = 1'b0;
        unique case (clock_source)
            ustw_pkg::CS_SOFT:
            begin
                shift_tick = soft_clock_strobe;
                count_tick = soft_clock_strobe;
            end
            ustw_pkg::CS_TIMER:
            begin
                shift_tick = timer_overflow;
                count_tick = timer_overflow;
            end
            ustw_pkg::CS_EXT_POS:
            begin
                shift_tick = rise_evt;
                count_tick = rise_evt | fall_evt;
            end
            ustw_pkg::CS_EXT_NEG:
            begin
                shift_tick = fall_evt;
                count_tick = rise_evt | fall_evt;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// shift register and counter

    logic [7:0] shift_next;
    assign shift_next = {shift_data_register[6:0], sda_link_reg};

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            shift_data_register <= ustw_pkg::SHIFT_RESET;
        else if (shift_data_write)
            shift_data_register <= shift_data_wdata;
        else if (shift_tick)
            shift_data_register <= shift_next;
    end

    logic cnt_wrap;
    assign cnt_wrap = count_tick && !counter_write
                      && counter_value == ustw_pkg::CNT_MAX;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            counter_value <= ustw_pkg::CNT_RESET;
        else if (counter_write)
            counter_value <= counter_wdata;
        else if (count_tick)
            counter_value <= counter_value + 4'h1;
    end

    // set wins over clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            counter_overflow_flag <= 1'b0;
        else if (cnt_wrap)
            counter_overflow_flag <= 1'b1;
        else if (clear_overflow)
            counter_overflow_flag <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            start_condition_flag <= 1'b0;
        else if (two_wire && start_ok)
            start_condition_flag <= 1'b1;
        else if (clear_start)
            start_condition_flag <= 1'b0;
    end

////////////////////////////////////////////////////////////////////////////////
// clock hold: after start once scl falls, and on overflow in MODE_TWOH

    logic start_hold_reg;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            start_hold_reg <= 1'b0;
        else if (!two_wire || (clear_start && !start_ok))
            start_hold_reg <= 1'b0;
        else if (start_condition_flag && fall_evt)
            start_hold_reg <= 1'b1;
    end

    logic hold_next;
    assign hold_next = two_wire && (start_hold_reg ||
                       (wire_mode == ustw_pkg::MODE_TWOH &&
                        counter_overflow_flag));

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_out  <= 1'b1;
            scl_oe_n <= 1'b1;
        end
        else
        begin
            scl_out  <= 1'b0;
            scl_oe_n <= ~hold_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// data output latch, open-drain in two-wire mode; no filtering

    logic latch_open;
    assign latch_open = !ext_src || scl_sync_reg[2] == 1'b0;

    logic out_bit_reg;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            out_bit_reg <= 1'b1;
        else if (latch_open)
            out_bit_reg <= shift_data_register[7];
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
        end
        else if (two_wire)
        begin
            sda_out  <= 1'b0;
            sda_oe_n <= ~(data_dir_out && !out_bit_reg);
        end
        else
        begin
            sda_out  <= out_bit_reg;
            sda_oe_n <= ~(data_dir_out && wire_mode != ustw_pkg::MODE_OFF);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// checks

    a_ovf_sets: assert property (@(posedge clock) disable iff (!reset_n)
        cnt_wrap |=> counter_overflow_flag)
        else $error("overflow flag not set on wrap");
    a_ovf_stays: assert property (@(posedge clock) disable iff (!reset_n)
        counter_overflow_flag && !clear_overflow |=> counter_overflow_flag)
        else $error("overflow flag dropped without clear");
    a_cnt_incr: assert property (@(posedge clock) disable iff (!reset_n)
        count_tick && !counter_write
        |=> counter_value == $past(counter_value) + 4'h1)
        else $error("counter did not step");
    a_start_sets: assert property (@(posedge clock) disable iff (!reset_n)
        two_wire && start_ok |=> start_condition_flag)
        else $error("start flag not set");
    a_start_stays: assert property (@(posedge clock) disable iff (!reset_n)
        start_condition_flag && !clear_start |=> start_condition_flag)
        else $error("start flag dropped without clear");
    a_hold_start: assert property (@(posedge clock) disable iff (!reset_n)
        start_hold_reg && two_wire |=> !scl_oe_n)
        else $error("scl not held after start");
    a_hold_ovf: assert property (@(posedge clock) disable iff (!reset_n)
        wire_mode == ustw_pkg::MODE_TWOH && counter_overflow_flag
        |=> !scl_oe_n)
        else $error("scl not held on overflow");
    a_shift_in: assert property (@(posedge clock) disable iff (!reset_n)
        shift_tick && !shift_data_write
        |=> shift_data_register == $past(shift_next))
        else $error("shift did not take data");
    a_no_hold_3w: assert property (@(posedge clock) disable iff (!reset_n)
        !two_wire ##1 !two_wire |-> scl_oe_n)
        else $error("clock held outside two-wire mode");

    c_start: cover property (@(posedge clock) disable iff (!reset_n)
        two_wire && start_evt);
    c_wrap: cover property (@(posedge clock) disable iff (!reset_n)
        cnt_wrap);
    c_hold: cover property (@(posedge clock) disable iff (!reset_n)
        !scl_oe_n ##1 scl_oe_n);
endmodule
`default_nettype wire

/* ustw_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ustw_unit_tb_top;
    logic       clock, reset_n, data_dir_out;
    logic [5:0] strobe;
    logic [1:0] wire_mode, clock_source;
    logic [7:0] shift_data_wdata, shift_data_register;
    logic [3:0] counter_wdata, counter_value;
    logic       sda_out, sda_oe_n, scl_out, scl_oe_n;
    logic       counter_overflow_flag, start_condition_flag;
    logic       scl_drv, sda_drv, stretch_timeout, scl_line, sda_line;
    int         failures, tests_run;

    // wired-and with pull-ups; three-wire output is a separate pin
    assign scl_line = scl_drv & (scl_oe_n | scl_out);
    assign sda_line = sda_drv & (sda_oe_n | sda_out
                      | (wire_mode == ustw_pkg::MODE_THREE));

    // strobe bits: soft, timer, counter write, clear ovf, clear start, load
    ustw_unit i_ustw_unit
    (
        .clock                 (clock),
        .reset_n               (reset_n),
        .scl_clock             (scl_line),
        .sda_in                (sda_line),
        .sda_out               (sda_out),
        .sda_oe_n              (sda_oe_n),
        .scl_out               (scl_out),
        .scl_oe_n              (scl_oe_n),
        .wire_mode             (wire_mode),
        .clock_source          (clock_source),
        .soft_clock_strobe     (strobe[0]),
        .timer_overflow        (strobe[1]),
        .data_dir_out          (data_dir_out),
        .shift_data_write      (strobe[5]),
        .shift_data_wdata      (shift_data_wdata),
        .counter_write         (strobe[2]),
        .counter_wdata         (counter_wdata),
        .clear_overflow        (strobe[3]),
        .clear_start           (strobe[4]),
        .shift_data_register   (shift_data_register),
        .counter_value         (counter_value),
        .counter_overflow_flag (counter_overflow_flag),
        .start_condition_flag  (start_condition_flag)
    );
    ustw_master i_ustw_master
    (
        .scl_line        (scl_line),
        .scl_drv         (scl_drv),
        .sda_drv         (sda_drv),
        .stretch_timeout (stretch_timeout)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic pulse(input int k);
        @(negedge clock);
        strobe = 6'h01 << k;
        @(negedge clock);
        strobe = 6'h00;
        repeat (20) @(negedge clock);
        // keeps link steps off both clock edges
        #1;
    endtask

    task automatic preset(input logic [3:0] v);
        counter_wdata = v;
        pulse(2);
        pulse(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_sources;
        for (int s = 0; s < 2; s++)
        begin
            clock_source = s[1:0];
            preset(4'hF);
            check("ovf cleared", counter_overflow_flag, 8'h00);
            pulse(s);
            check("count wrap", counter_value, 8'h00);
            check("ovf set", counter_overflow_flag, 8'h01);
        end
    endtask

    task automatic t_ext;
        clock_source = ustw_pkg::CS_EXT_POS;
        preset(4'hF);
        i_ustw_master.edge_scl(1'b0);
        check("ext ovf", counter_overflow_flag, 8'h01);
        i_ustw_master.edge_scl(1'b1);
        check("both edges", counter_value, 8'h01);
    endtask

    task automatic t_two;
        pulse(3);
        wire_mode = ustw_pkg::MODE_TWOH;
        pulse(4);
        i_ustw_master.start_cond();
        check("start flag", start_condition_flag, 8'h01);
        check("start hold", scl_oe_n, 8'h00);
        check("hold drive", scl_out, 8'h00);
        pulse(4);
        preset(4'h0);
        check("hold released", scl_oe_n, 8'h01);
        check("start cleared", start_condition_flag, 8'h00);
        i_ustw_master.send_byte(8'hA6);
        check("address", shift_data_register, 8'hA6);
        check("byte ovf", counter_overflow_flag, 8'h01);
        check("byte hold", scl_oe_n, 8'h00);
        preset(4'hE);
        check("ovf release", scl_oe_n, 8'h01);
        i_ustw_master.send_bit(1'b1);
        check("ack hold", scl_oe_n, 8'h00);
        pulse(3);
        i_ustw_master.stop_cond();
        check("idle", scl_oe_n, 8'h01);
        pulse(4);
        i_ustw_master.start_cond();
        check("restart flag", start_condition_flag, 8'h01);
        pulse(4);
        wire_mode = ustw_pkg::MODE_TWO;
        preset(4'hF);
        i_ustw_master.edge_scl(1'b1);
        check("two ovf", counter_overflow_flag, 8'h01);
        check("no ovf hold", scl_oe_n, 8'h01);
    endtask

    task automatic t_three;
        wire_mode = ustw_pkg::MODE_THREE;
        data_dir_out = 1'b1;
        i_ustw_master.edge_scl(1'b0);
        shift_data_wdata = 8'h81;
        pulse(5);
        preset(4'h0);
        check("msb out", sda_out, 8'h01);
        check("out enabled", sda_oe_n, 8'h00);
        i_ustw_master.send_byte(8'h5A);
        check("slave byte", shift_data_register, 8'h5A);
        check("slave done", counter_overflow_flag, 8'h01);
        i_ustw_master.edge_scl(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        tests_run = 0;
        reset_n = 1'b0;
        {wire_mode, clock_source, data_dir_out} = 5'h00;
        strobe = 6'h00;
        shift_data_wdata = 8'h00;
        counter_wdata = 4'h0;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        t_sources();
        t_ext();
        t_two();
        t_three();
        check("stretch wait", stretch_timeout, 8'h00);
        test_done();
    end

    initial
    begin
        #400000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
